/* File: hdl/twrsp_defs.svh */
// Purpose: Constants for the two-wire register slave port and its master end
// Assumes: System clock of 250 MHz on both ends
// Notes: Timing counts are derived from times, never typed in as cycles
`ifndef TWRSP_DEFS_SVH
`define TWRSP_DEFS_SVH

// Upper six bits of the 7-bit slave address, last bit from the strap pin
`define TWRSP_ADDR_PREFIX 6'h26
// Highest register index; writes and reads saturate here
`define TWRSP_REG_MAX 8'h1e
// Bit counter values: 8 data bits, then the acknowledge slot
`define TWRSP_ACK_SLOT 4'h8
`define TWRSP_BYTE_END 4'h9
// Reset values
`define TWRSP_BYTE_RST 8'h00
`define TWRSP_CNT_RST 4'h0

// Master clock generation: bus clock period and system clock rate
`define TWRSP_SCL_PERIOD_NS 10000
`define TWRSP_CLK_MHZ 250
// Cycles per quarter bus period, rounded down
`define TWRSP_SCL_QTR_CYC ((`TWRSP_SCL_PERIOD_NS * `TWRSP_CLK_MHZ) / 4000)

`endif

/* File: hdl/twrsp_pkg.sv */
// Purpose: Types shared by both ends of the two-wire register port
// Assumes: Constants come from twrsp_defs.svh
// Notes: Slave state codes are Gray along the write path
package twrsp_pkg;

  // Slave protocol phases
  typedef enum logic [2:0] {
    DEV_IDLE = 3'h0,
    DEV_ADDR = 3'h1,
    DEV_REG = 3'h3,
    DEV_WRITE = 3'h2,
    DEV_READ = 3'h6
  } twrsp_dev_state_t;

  // Master sequencer phases
  typedef enum logic [1:0] {
    HST_IDLE = 2'h0,
    HST_START = 2'h1,
    HST_BIT = 2'h3,
    HST_STOP = 2'h2
  } twrsp_hst_state_t;

  // Byte-level commands of the master end
  typedef enum logic [1:0] {
    CMD_START = 2'h0,
    CMD_WRITE = 2'h1,
    CMD_READ = 2'h2,
    CMD_STOP = 2'h3
  } twrsp_cmd_t;

endpackage

/* File: hdl/twrsp_if.sv */
// Purpose: Open-drain clock and data lines between master and slave
// Assumes: Pull-ups hold both lines high when nobody pulls low
// Notes: An enable low means that party pulls the line low
`timescale 1ns/1ps
interface twrsp_if;
  logic scl_host_oen;
  logic sda_host_oen;
  logic sda_dev_oen;
  logic scl;
  logic sda;

  // Wired-AND resolution of the pulled-up lines
  assign scl = scl_host_oen;
  assign sda = sda_host_oen & sda_dev_oen;

  modport dev (input scl, input sda, output sda_dev_oen);
  modport host (input scl, input sda, output scl_host_oen, output sda_host_oen);
endinterface

/* File: hdl/twrsp_dev.sv */
// Purpose: Slave end of the two-wire register port
// Assumes: Bus lines come from another clock domain and are synchronised here
// Notes: Register storage lives outside; this end only reads and writes it
`timescale 1ns/1ps
`include "twrsp_defs.svh"
module twrsp_dev #(
  parameter logic [7:0] REG_MAX = `TWRSP_REG_MAX
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Two-wire bus
  twrsp_if.dev bus,
  // Address strap
  input wire logic address_select_pin_in,
  // Register file write port
  output logic wr_stb_out,
  output logic [7:0] wr_addr_out,
  output logic [7:0] wr_data_out,
  // Register file read port
  output logic [7:0] rd_addr_out,
  input wire logic [7:0] rd_data_in
);

  // A pointer stuck at all ones could never saturate below wrap
  if (REG_MAX == 8'hff) begin : g_chk
    $error("REG_MAX must leave room below 8'hff");
  end

  // Saturating pointer advance
  function automatic logic [7:0] sat_inc(input logic [7:0] ptr);
    logic [7:0] res;
    res = ptr;
    if (ptr < REG_MAX) begin
      res = 8'(ptr + 8'h01);
    end
    return res;
  endfunction

  twrsp_pkg::twrsp_dev_state_t state_r;
  logic [2:0] scl_sync_r;
  logic [2:0] sda_sync_r;
  logic [1:0] asel_sync_r;
  logic [3:0] cnt_r;
  logic [7:0] shift_r;
  logic [7:0] ptr_r;
  logic sda_oen_r;
  logic rw_r;
  logic mack_r;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;
  logic addr_match;
  logic byte_wr;

  // two-stage synchronisers
  // Stage 0 feeds only stage 1; stage 2 is the previous sample for edges
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_sync_r <= 3'h7;
      sda_sync_r <= 3'h7;
      asel_sync_r <= 2'h0;
    end else begin
      scl_sync_r <= {scl_sync_r[1:0], bus.scl};
      sda_sync_r <= {sda_sync_r[1:0], bus.sda};
      asel_sync_r <= {asel_sync_r[0], address_select_pin_in};
    end
  end

  assign scl_rise = scl_sync_r[1] & ~scl_sync_r[2];
  assign scl_fall = ~scl_sync_r[1] & scl_sync_r[2];
  // data moving during clock high is framing
  assign start_det = scl_sync_r[1] & scl_sync_r[2] & sda_sync_r[2] & ~sda_sync_r[1];
  assign stop_det = scl_sync_r[1] & scl_sync_r[2] & ~sda_sync_r[2] & sda_sync_r[1];

  assign addr_match = (shift_r[7:1] == {`TWRSP_ADDR_PREFIX, asel_sync_r[1]});

  // A data byte is committed when its acknowledge slot opens
  assign byte_wr = (state_r == twrsp_pkg::DEV_WRITE) && scl_fall && (cnt_r == `TWRSP_ACK_SLOT)
    && !start_det && !stop_det;

  // Protocol sequencer: phase, bit count, shifter and data line
  // slave only, never drives the clock line
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= twrsp_pkg::DEV_IDLE;
      cnt_r <= `TWRSP_CNT_RST;
      shift_r <= `TWRSP_BYTE_RST;
      ptr_r <= `TWRSP_BYTE_RST;
      sda_oen_r <= 1'b1;
      rw_r <= 1'b0;
      mack_r <= 1'b0;
    end else if (start_det) begin
      state_r <= twrsp_pkg::DEV_ADDR;
      cnt_r <= `TWRSP_CNT_RST;
      sda_oen_r <= 1'b1;
    end else if (stop_det) begin
      state_r <= twrsp_pkg::DEV_IDLE;
      cnt_r <= `TWRSP_CNT_RST;
      sda_oen_r <= 1'b1;
    end else if (state_r != twrsp_pkg::DEV_IDLE) begin
      if (scl_rise) begin
        cnt_r <= 4'(cnt_r + 4'h1);
        if (cnt_r < `TWRSP_ACK_SLOT && state_r != twrsp_pkg::DEV_READ) begin
          shift_r <= {shift_r[6:0], sda_sync_r[1]};
        end
        // master acknowledge sampled on ninth pulse
        if (cnt_r == `TWRSP_ACK_SLOT && state_r == twrsp_pkg::DEV_READ) begin
          mack_r <= ~sda_sync_r[1];
        end
      end else if (scl_fall) begin
        if (cnt_r == `TWRSP_ACK_SLOT) begin
          case (state_r)
            twrsp_pkg::DEV_ADDR: begin
              if (addr_match) begin
                sda_oen_r <= 1'b0;
                rw_r <= shift_r[0];
              end else begin
                state_r <= twrsp_pkg::DEV_IDLE;
              end
            end
            twrsp_pkg::DEV_REG: begin
              // base beyond top gets no acknowledge
              // line left released for the stop
              if (shift_r <= REG_MAX) begin
                sda_oen_r <= 1'b0;
                ptr_r <= shift_r;
              end else begin
                state_r <= twrsp_pkg::DEV_IDLE;
              end
            end
            twrsp_pkg::DEV_WRITE: begin
              sda_oen_r <= 1'b0;
              // advance after write, hold at top
              ptr_r <= sat_inc(ptr_r);
            end
            twrsp_pkg::DEV_READ: begin
              // Master owns the acknowledge slot
              sda_oen_r <= 1'b1;
              ptr_r <= sat_inc(ptr_r);
            end
            default: begin
              state_r <= twrsp_pkg::DEV_IDLE;
            end
          endcase
        end else if (cnt_r == `TWRSP_BYTE_END) begin
          cnt_r <= `TWRSP_CNT_RST;
          sda_oen_r <= 1'b1;
          case (state_r)
            twrsp_pkg::DEV_ADDR: begin
              if (rw_r) begin
                state_r <= twrsp_pkg::DEV_READ;
                shift_r <= rd_data_in;
                sda_oen_r <= rd_data_in[7];
              end else begin
                state_r <= twrsp_pkg::DEV_REG;
              end
            end
            twrsp_pkg::DEV_REG: begin
              state_r <= twrsp_pkg::DEV_WRITE;
            end
            twrsp_pkg::DEV_WRITE: begin
              state_r <= twrsp_pkg::DEV_WRITE;
            end
            twrsp_pkg::DEV_READ: begin
              if (mack_r) begin
                shift_r <= rd_data_in;
                sda_oen_r <= rd_data_in[7];
              end else begin
                // end of data, release for stop
                state_r <= twrsp_pkg::DEV_IDLE;
              end
            end
            default: begin
              state_r <= twrsp_pkg::DEV_IDLE;
            end
          endcase
        end else if (state_r == twrsp_pkg::DEV_READ && cnt_r < `TWRSP_ACK_SLOT) begin
          // drive next bit, most significant first
          // data changes only after clock falls
          sda_oen_r <= shift_r[3'h7 - cnt_r[2:0]];
        end
      end
    end
  end

  // open drain: enable low pulls low, high releases
  assign bus.sda_dev_oen = sda_oen_r;

  // Register file write strobe; pointer before the advance
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      wr_stb_out <= 1'b0;
      wr_addr_out <= `TWRSP_BYTE_RST;
      wr_data_out <= `TWRSP_BYTE_RST;
    end else begin
      wr_stb_out <= byte_wr;
      if (byte_wr) begin
        wr_addr_out <= ptr_r;
        wr_data_out <= shift_r;
      end
    end
  end

  // Read address follows the pointer; data is taken one bus clock period later
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rd_addr_out <= `TWRSP_BYTE_RST;
    end else begin
      rd_addr_out <= ptr_r;
    end
  end

endmodule

/* File: hdl/twrsp_host.sv */
// Purpose: Master end of the two-wire register port, byte-level commands
// Assumes: Slave never stretches the clock
// Notes: Bus clock made by a divider; one tick per quarter bus period
`timescale 1ns/1ps
`include "twrsp_defs.svh"
module twrsp_host #(
  parameter int QTR_CYC = `TWRSP_SCL_QTR_CYC
) (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Two-wire bus
  twrsp_if.host bus,
  // Command port
  input wire logic cmd_valid_in,
  input wire twrsp_pkg::twrsp_cmd_t cmd_in,
  input wire logic [7:0] tx_byte_in,
  input wire logic mack_in,
  output logic cmd_ready_out,
  // Result port
  output logic done_out,
  output logic [7:0] rx_byte_out,
  output logic rx_nack_out
);

  // Sampling needs the two-stage synchroniser to settle inside a quarter
  if (QTR_CYC < 4 || QTR_CYC > 65535) begin : g_chk
    $error("QTR_CYC out of range");
  end

  twrsp_pkg::twrsp_hst_state_t state_r;
  logic [15:0] qcnt_r;
  logic [1:0] phase_r;
  logic [3:0] bit_r;
  logic [7:0] tx_r;
  logic [7:0] rx_r;
  logic rd_r;
  logic mack_r;
  logic nack_r;
  logic scl_oen_r;
  logic sda_oen_r;
  logic [1:0] sda_sync_r;
  logic tick;
  logic accept;

  assign accept = cmd_valid_in && cmd_ready_out;
  assign tick = (state_r != twrsp_pkg::HST_IDLE) && (qcnt_r == 16'(QTR_CYC - 1));

  // Data line synchroniser, only stage 1 is sampled
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sda_sync_r <= 2'h3;
    end else begin
      sda_sync_r <= {sda_sync_r[0], bus.sda};
    end
  end

  // Quarter-period divider, runs only while busy
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      qcnt_r <= 16'h0000;
    end else if (state_r == twrsp_pkg::HST_IDLE || tick) begin
      qcnt_r <= 16'h0000;
    end else begin
      qcnt_r <= 16'(qcnt_r + 16'h0001);
    end
  end

  // Sequencer: start, nine-bit byte slots and stop
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      state_r <= twrsp_pkg::HST_IDLE;
      phase_r <= 2'h0;
      bit_r <= `TWRSP_CNT_RST;
      tx_r <= `TWRSP_BYTE_RST;
      rx_r <= `TWRSP_BYTE_RST;
      rd_r <= 1'b0;
      mack_r <= 1'b0;
      nack_r <= 1'b1;
      scl_oen_r <= 1'b1;
      sda_oen_r <= 1'b1;
      cmd_ready_out <= 1'b1;
      done_out <= 1'b0;
      rx_byte_out <= `TWRSP_BYTE_RST;
      rx_nack_out <= 1'b0;
    end else begin
      done_out <= 1'b0;
      if (accept) begin
        cmd_ready_out <= 1'b0;
        phase_r <= 2'h0;
        bit_r <= `TWRSP_CNT_RST;
        rd_r <= (cmd_in == twrsp_pkg::CMD_READ);
        mack_r <= mack_in;
        // A read shifts out all ones so the slave owns the line
        tx_r <= (cmd_in == twrsp_pkg::CMD_READ) ? 8'hff : tx_byte_in;
        case (cmd_in)
          twrsp_pkg::CMD_START: state_r <= twrsp_pkg::HST_START;
          twrsp_pkg::CMD_STOP: state_r <= twrsp_pkg::HST_STOP;
          default: state_r <= twrsp_pkg::HST_BIT;
        endcase
      end else if (tick) begin
        phase_r <= 2'(phase_r + 2'h1);
        case (state_r)
          twrsp_pkg::HST_START: begin
            // Release, raise clock, pull data low, lower clock
            case (phase_r)
              2'h0: sda_oen_r <= 1'b1;
              2'h1: scl_oen_r <= 1'b1;
              2'h2: sda_oen_r <= 1'b0;
              default: scl_oen_r <= 1'b0;
            endcase
          end
          twrsp_pkg::HST_BIT: begin
            case (phase_r)
              2'h0: begin
                // Data set while clock low, ack slot driven per command
                if (bit_r < `TWRSP_ACK_SLOT) begin
                  sda_oen_r <= tx_r[7];
                end else begin
                  sda_oen_r <= !(rd_r && mack_r);
                end
              end
              2'h1: scl_oen_r <= 1'b1;
              2'h2: begin
                if (bit_r < `TWRSP_ACK_SLOT) begin
                  rx_r <= {rx_r[6:0], sda_sync_r[1]};
                end else begin
                  nack_r <= sda_sync_r[1];
                end
              end
              default: begin
                scl_oen_r <= 1'b0;
                tx_r <= {tx_r[6:0], 1'b1};
                bit_r <= 4'(bit_r + 4'h1);
                if (bit_r == `TWRSP_ACK_SLOT) begin
                  sda_oen_r <= 1'b1;
                end
              end
            endcase
          end
          twrsp_pkg::HST_STOP: begin
            // Pull data low, raise clock, release data
            case (phase_r)
              2'h0: sda_oen_r <= 1'b0;
              2'h1: scl_oen_r <= 1'b1;
              2'h2: sda_oen_r <= 1'b1;
              default: scl_oen_r <= 1'b1;
            endcase
          end
          default: state_r <= twrsp_pkg::HST_IDLE;
        endcase
        // Command finishes on the last quarter of its final slot
        if (phase_r == 2'h3 && (state_r != twrsp_pkg::HST_BIT || bit_r == `TWRSP_ACK_SLOT)) begin
          state_r <= twrsp_pkg::HST_IDLE;
          cmd_ready_out <= 1'b1;
          done_out <= 1'b1;
          if (state_r == twrsp_pkg::HST_BIT) begin
            rx_byte_out <= rx_r;
            rx_nack_out <= nack_r;
          end
        end
      end
    end
  end

  // Open drain: enable low pulls the line low
  assign bus.scl_host_oen = scl_oen_r;
  assign bus.sda_host_oen = sda_oen_r;

endmodule

/* File: tb/twrsp_properties.sv */
// Purpose: Wire checks on the slave end of the two-wire port
// Assumes: Bus clock far slower than clk_in
// Notes: Edges come from raw line samples on clk_in, two cycles ahead of the slave's synchronised view
`timescale 1ns/1ps
module twrsp_properties (
  // Clock and reset
  input wire logic clk_in,
  input wire logic resetn_in,
  // Bus lines
  input wire logic scl_host_oen,
  input wire logic sda_host_oen,
  input wire logic sda_dev_oen,
  input wire logic scl,
  input wire logic sda,
  // Address strap
  input wire logic address_select_pin_in
);
  logic scl_r, sda_r, rise, start, stop, slot, hit, wok;
  logic [3:0] bit_r;
  logic [1:0] byt_r;
  logic [7:0] sh_r, adr_r, reg_r;
  // Line events against the previous sample
  assign rise = scl & ~scl_r;
  assign start = scl & scl_r & sda_r & ~sda;
  assign stop = scl & scl_r & ~sda_r & sda;
  assign slot = rise & (bit_r == 4'h8);
  assign hit = adr_r[7:1] == {6'h26, address_select_pin_in};
  assign wok = hit & ~adr_r[0] & (reg_r <= 8'h1e);
  // Previous line samples
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      scl_r <= 1'b1;
      sda_r <= 1'b1;
    end else begin
      scl_r <= scl;
      sda_r <= sda;
    end
  end
  // Bit and byte position; a start restarts both
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bit_r <= 4'h0;
      byt_r <= 2'h0;
    end else if (start) begin
      bit_r <= 4'h0;
      byt_r <= 2'h0;
    end else if (rise) begin
      bit_r <= (bit_r == 4'h8) ? 4'h0 : bit_r + 4'h1;
      if (bit_r == 4'h8 && byt_r != 2'h3) byt_r <= byt_r + 2'h1;
    end
  end
  // Byte capture, first bit lands on top
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sh_r <= 8'h00;
      adr_r <= 8'h00;
      reg_r <= 8'h00;
    end else if (rise) begin
      sh_r <= {sh_r[6:0], sda};
      if (bit_r == 4'h7 && byt_r == 2'h0) adr_r <= {sh_r[6:0], sda};
      if (bit_r == 4'h7 && byt_r == 2'h1) reg_r <= {sh_r[6:0], sda};
    end
  end
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_free8; sda_dev_oen [*8]; endsequence
  sequence s_addr_slot; slot && byt_r == 2'h0; endsequence
  sequence s_until_end; ##[0:80] (start || stop); endsequence
  property p_hold_high; $changed(sda_dev_oen) |-> !scl; endproperty
  a_hold_high: assert property (p_hold_high) else $error("slave data moved while clock high");
  property p_start_free; start |=> s_free8; endproperty
  a_start_free: assert property (p_start_free) else $error("slave drove data after start");
  property p_addr_ack; s_addr_slot |-> sda_dev_oen != hit; endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address acknowledge wrong");
  property p_reg_ack; slot && byt_r == 2'h1 && hit && !adr_r[0] |-> sda_dev_oen == (reg_r > 8'h1e); endproperty
  a_reg_ack: assert property (p_reg_ack) else $error("register address acknowledge wrong");
  property p_data_ack; slot && byt_r[1] && wok |-> !sda_dev_oen; endproperty
  a_data_ack: assert property (p_data_ack) else $error("data byte not acknowledged");
  property p_nack_quiet; (s_addr_slot and !hit) |-> sda_dev_oen throughout s_until_end; endproperty
  a_nack_quiet: assert property (p_nack_quiet) else $error("slave drove data after no acknowledge");
  property p_read_end; slot && byt_r != 2'h0 && hit && adr_r[0] && sda |-> sda_dev_oen throughout s_until_end; endproperty
  a_read_end: assert property (p_read_end) else $error("slave kept sending after end of data");
  property p_stop_free; stop |=> s_free8; endproperty
  a_stop_free: assert property (p_stop_free) else $error("slave drove data after stop");
endmodule

/* File: tb/test_two_wire_register_slave_port.sv */
// Purpose: Master and slave ends joined, driven through master commands
// Assumes: Short bus period through QTR_CYC for a quick run
// Notes: Register file modelled here, fed by the slave's ports
`timescale 1ns/1ps
module test_two_wire_register_slave_port;
  logic clk_in, resetn_in, cmd_valid, mack, asel, cmd_ready, done, rx_nack, wr_stb;
  twrsp_pkg::twrsp_cmd_t cmd;
  logic [7:0] tx, rx_byte, wr_addr, wr_data, rd_addr, rd_data;
  logic [7:0] mem [0:31];
  logic [15:0] wlog [$];
  int miscompares, total_checks, cycles;
  twrsp_if u_twrsp_if ();
  twrsp_host #(.QTR_CYC(8)) u_twrsp_host (.clk_in(clk_in), .resetn_in(resetn_in), .bus(u_twrsp_if),
    .cmd_valid_in(cmd_valid), .cmd_in(cmd), .tx_byte_in(tx), .mack_in(mack), .cmd_ready_out(cmd_ready),
    .done_out(done), .rx_byte_out(rx_byte), .rx_nack_out(rx_nack));
  twrsp_dev u_twrsp_dev (.clk_in(clk_in), .resetn_in(resetn_in), .bus(u_twrsp_if), .address_select_pin_in(asel),
    .wr_stb_out(wr_stb), .wr_addr_out(wr_addr), .wr_data_out(wr_data), .rd_addr_out(rd_addr), .rd_data_in(rd_data));
  twrsp_properties u_twrsp_properties (.clk_in(clk_in), .resetn_in(resetn_in),
    .scl_host_oen(u_twrsp_if.scl_host_oen), .sda_host_oen(u_twrsp_if.sda_host_oen),
    .sda_dev_oen(u_twrsp_if.sda_dev_oen), .scl(u_twrsp_if.scl), .sda(u_twrsp_if.sda), .address_select_pin_in(asel));
  // 250 MHz clock
  initial begin
    clk_in = 1'b0;
    forever #2 clk_in = ~clk_in;
  end
  // Register file: writes logged for later comparison
  assign rd_data = mem[rd_addr[4:0]];
  always @(posedge clk_in) begin
    if (wr_stb === 1'b1) begin
      wlog.push_back({wr_addr, wr_data});
      mem[wr_addr[4:0]] <= wr_data;
    end
  end
  // Hang guard, well above the nineteen bytes sent
  always @(posedge clk_in) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      end_of_test();
    end
  end
  task automatic end_of_test();
    $display("Checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // One master command; valid held for one cycle, then wait for done
  task automatic op(input twrsp_pkg::twrsp_cmd_t c, input logic [7:0] b, input logic m);
    int n;
    n = 0;
    @(negedge clk_in);
    cmd_valid = 1'b1;
    cmd = c;
    tx = b;
    mack = m;
    @(negedge clk_in);
    while (done !== 1'b1 && n < 1000) begin
      cmd_valid = 1'b0;
      @(negedge clk_in);
      n++;
    end
    cmd_valid = 1'b0;
    if (n >= 1000) begin
      miscompares++;
      end_of_test();
    end
  endtask
  task automatic wb(input logic [7:0] b, input logic nack);
    op(twrsp_pkg::CMD_WRITE, b, 1'b0);
    check("ack slot", {15'h0, nack}, {15'h0, rx_nack});
  endtask
  task automatic rb(input logic m, input logic [7:0] exp);
    op(twrsp_pkg::CMD_READ, 8'h00, m);
    check("read byte", {8'h00, exp}, {8'h00, rx_byte});
  endtask
  task automatic stop_idle();
    op(twrsp_pkg::CMD_STOP, 8'h00, 1'b0);
    check("idle lines", 16'h0003, {14'h0, u_twrsp_if.scl, u_twrsp_if.sda});
    check("ready", 16'h0001, {15'h0, cmd_ready});
  endtask
  initial begin
    resetn_in = 1'b0;
    cmd_valid = 1'b0;
    cmd = twrsp_pkg::CMD_START;
    tx = 8'h00;
    mack = 1'b0;
    asel = 1'b0;
    miscompares = 0;
    total_checks = 0;
    cycles = 0;
    for (int i = 0; i < 32; i++) mem[i] = 8'h5a ^ 8'(i);
    repeat (10) @(posedge clk_in);
    @(negedge clk_in);
    resetn_in = 1'b1;
    // Burst write running past the top register
    op(twrsp_pkg::CMD_START, 8'h00, 1'b0);
    wb(8'h98, 1'b0);
    wb(8'h1c, 1'b0);
    wb(8'ha1, 1'b0);
    wb(8'hb2, 1'b0);
    wb(8'hc3, 1'b0);
    wb(8'hd4, 1'b0);
    stop_idle();
    check("write count", 16'h0004, 16'(wlog.size()));
    check("write 0", 16'h1ca1, wlog[0]);
    check("write 1", 16'h1db2, wlog[1]);
    check("write 2", 16'h1ec3, wlog[2]);
    check("write 3", 16'h1ed4, wlog[3]);
    // Base one past the top is refused, nothing written
    op(twrsp_pkg::CMD_START, 8'h00, 1'b0);
    wb(8'h98, 1'b0);
    wb(8'h1f, 1'b1);
    stop_idle();
    // Address differing only in the strap bit
    op(twrsp_pkg::CMD_START, 8'h00, 1'b0);
    wb(8'h9a, 1'b1);
    stop_idle();
    check("write count", 16'h0004, 16'(wlog.size()));
    // Set base, repeated start, read three with end of data
    op(twrsp_pkg::CMD_START, 8'h00, 1'b0);
    wb(8'h98, 1'b0);
    wb(8'h10, 1'b0);
    op(twrsp_pkg::CMD_START, 8'h00, 1'b0);
    wb(8'h99, 1'b0);
    rb(1'b1, 8'h5a ^ 8'h10);
    rb(1'b1, 8'h5a ^ 8'h11);
    rb(1'b0, 8'h5a ^ 8'h12);
    check("master no ack", 16'h0001, {15'h0, rx_nack});
    stop_idle();
    // Strap high moves the slave address
    asel = 1'b1;
    repeat (4) @(negedge clk_in);
    op(twrsp_pkg::CMD_START, 8'h00, 1'b0);
    wb(8'h9a, 1'b0);
    wb(8'h05, 1'b0);
    wb(8'h77, 1'b0);
    stop_idle();
    check("strap write", 16'h0577, wlog[4]);
    op(twrsp_pkg::CMD_START, 8'h00, 1'b0);
    wb(8'h98, 1'b1);
    stop_idle();
    end_of_test();
  end
endmodule
